// ===== verilog/tsx_pkg.sv
// constants and types of the transmit serializer status block
package tsx_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_IRQ_ENABLE = 6'h0D;
  localparam logic [5:0] OFS_EVENT_FLAGS = 6'h0E;
  localparam logic [5:0] OFS_BYTE_HOLDING = 6'h0F;
  localparam logic [5:0] OFS_QUALIFIER_MASK = 6'h10;

  // ****************************************
  // field layout and reset values
  // ****************************************
  localparam int FLAG_UNDERFLOW = 3;
  localparam int FLAG_OVERFLOW = 2;
  localparam int FLAG_DONE = 1;
  localparam int FLAG_EMPTY = 0;
  localparam int FLAG_W = 4;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [3:0] READ_CLEAR_MASK = 4'hE;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] RSVD_ZERO = 4'h0;
  localparam int FIFO_DEPTH = 16;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } tsx_reg_req_t;

  typedef struct packed {
    logic is_data;
    logic value;
  } tsx_sym_t;

endpackage

// ===== verilog/tsx_serializer.sv
// bit fifo and transmit serializer with status flags
`timescale 1ns/1ps

// ****************************************
// fifo of symbols toward the modulator
// ****************************************
module tsx_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PTR_W = $clog2(DEPTH);

  // refuse a depth the wrapping pointers cannot serve
  if (DEPTH < 2 || (1 << PTR_W) != DEPTH || WIDTH < 1) begin : g_bad_size
    $error("tsx_fifo depth must be a power of two, width above zero");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  // pointers carry one extra wrap bit
  logic [PTR_W:0] wr_ptr;
  logic [PTR_W:0] rd_ptr;
  wire logic full;
  wire logic empty;
  wire logic push;
  wire logic pop;

  // full when pointers differ only in the wrap bit
  assign full = (wr_ptr[PTR_W] != rd_ptr[PTR_W]) &&
                (wr_ptr[PTR_W-1:0] == rd_ptr[PTR_W-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign push = in_valid_i && !full;
  assign pop = out_ready_i && !empty;
  assign out_data_o = mem[rd_ptr[PTR_W-1:0]];

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr[PTR_W-1:0]] <= in_data_i;
    end
  end
endmodule

// ****************************************
// transmit serializer top
// ****************************************
module tsx_serializer
  import tsx_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // register access from the serial host port
  input wire tsx_reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // transmit mode from the control register
  input wire logic tx_mode_i,
  // symbol stream toward the modulator
  output logic sym_valid_o,
  input wire logic sym_ready_i,
  output tsx_sym_t sym_o,
  // interrupt request
  output logic irq_o
);
  // ****************************************
  // parameter check
  // ****************************************
  // the symbol fifo needs a power of two depth of at least two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("tsx_serializer depth must be a power of two of at least 2");
  end

  // ****************************************
  // helpers
  // ****************************************
  // true when the request addresses the given register
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] ofs);
    return addr == ofs;
  endfunction

  // one-hot mask of a single flag position
  function automatic logic [FLAG_W-1:0] flag_bit(input int pos);
    return FLAG_W'(1) << pos;
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [3:0] irq_enable;
  logic [3:0] flags;
  logic [7:0] hold_data;
  logic [7:0] hold_mask;
  logic hold_full;
  logic [7:0] sh_data;
  logic [7:0] sh_mask;
  logic sent_any;

  // ****************************************
  // decode
  // ****************************************
  wire logic hit_irq_enable;
  wire logic hit_flags;
  wire logic hit_holding;
  wire logic hit_mask;
  wire logic wr_en_reg;
  wire logic wr_hold;
  wire logic wr_mask;
  wire logic rd_flags;
  wire logic fifo_ready;
  wire logic step;
  wire logic sh_busy;
  wire logic shift_bit;
  wire logic load;
  wire logic last_bit;
  wire logic [3:0] vis_flags;
  wire logic [3:0] set_flags;
  wire logic [3:0] rd_clear;
  wire logic [3:0] wr_clear;
  wire logic [3:0] clr_flags;
  wire logic [3:0] next_flags;
  wire logic [7:0] rd_mux;
  wire tsx_sym_t push_sym;

  // register address decode, shared by write and read paths
  assign hit_irq_enable = reg_hit(reg_req_i.addr, OFS_IRQ_ENABLE);
  assign hit_flags = reg_hit(reg_req_i.addr, OFS_EVENT_FLAGS);
  assign hit_holding = reg_hit(reg_req_i.addr, OFS_BYTE_HOLDING);
  assign hit_mask = reg_hit(reg_req_i.addr, OFS_QUALIFIER_MASK);
  // write and read strobes
  assign wr_en_reg = reg_req_i.wr && hit_irq_enable;
  assign wr_hold = reg_req_i.wr && hit_holding;
  assign wr_mask = reg_req_i.wr && hit_mask;
  assign rd_flags = reg_req_i.rd && hit_flags;

  // ****************************************
  // shifter control
  // ****************************************

  // the shifter advances only when the fifo can take a symbol
  assign step = tx_mode_i && fifo_ready;
  assign sh_busy = |sh_mask;
  assign shift_bit = step && sh_busy;
  assign load = step && !sh_busy && hold_full;
  assign last_bit = shift_bit && (sh_mask[7:1] == 7'h00);

  assign push_sym = '{is_data: sh_mask[0], value: sh_mask[0] & sh_data[0]};

  // ****************************************
  // flag update
  // ****************************************
  // underflow after a bit
  assign set_flags[FLAG_UNDERFLOW] = step && !sh_busy && !hold_full &&
                                     sent_any;
  assign set_flags[FLAG_OVERFLOW] = wr_hold && hold_full && !load;
  assign set_flags[FLAG_DONE] = last_bit && !hold_full;
  assign set_flags[FLAG_EMPTY] = load;

  assign rd_clear = rd_flags ? READ_CLEAR_MASK : FLAGS_RESET;
  assign wr_clear = wr_hold ? flag_bit(FLAG_EMPTY) : FLAGS_RESET;
  assign clr_flags = rd_clear | wr_clear;
  // set wins over clear
  assign next_flags = (flags & ~clr_flags) | set_flags;

  assign vis_flags = tx_mode_i ? flags : FLAGS_RESET;

  // ****************************************
  // read path
  // ****************************************
  // read only, reserved zero
  assign rd_mux = hit_irq_enable ? {RSVD_ZERO, irq_enable} :
                  hit_flags ? {RSVD_ZERO, vis_flags} :
                  hit_holding ? hold_data :
                  hit_mask ? hold_mask :
                  BYTE_RESET;

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_enable <= FLAGS_RESET;
      flags <= FLAGS_RESET;
    end else begin
      if (wr_en_reg) begin
        irq_enable <= reg_req_i.wdata[FLAG_W-1:0];
      end
      flags <= next_flags;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      hold_data <= BYTE_RESET;
      hold_mask <= BYTE_RESET;
      hold_full <= 1'b0;
    end else begin
      if (wr_hold) begin
        hold_data <= reg_req_i.wdata;
      end
      if (wr_mask) begin
        hold_mask <= reg_req_i.wdata;
      end
      hold_full <= wr_hold || (hold_full && !load);
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sh_data <= BYTE_RESET;
      sh_mask <= BYTE_RESET;
    end else if (load) begin
      sh_data <= hold_data;
      sh_mask <= hold_mask;
    end else if (shift_bit) begin
      sh_data <= {1'b0, sh_data[7:1]};
      sh_mask <= {1'b0, sh_mask[7:1]};
    end
  end

  // any bit sent since transmit mode began
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sent_any <= 1'b0;
    end else begin
      sent_any <= tx_mode_i && (sent_any || shift_bit);
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= BYTE_RESET;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_req_i.rd;
      if (reg_req_i.rd) begin
        reg_rdata_o <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= tx_mode_i && |(next_flags & irq_enable);
    end
  end

  // ****************************************
  // symbol fifo
  // ****************************************
  tsx_fifo #(
    .WIDTH($bits(tsx_sym_t)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .in_valid_i(shift_bit),
    .in_ready_o(fifo_ready),
    .in_data_i(push_sym),
    .out_valid_o(sym_valid_o),
    .out_ready_i(sym_ready_i),
    .out_data_o(sym_o)
  );
endmodule

// ===== tb/tsx_sink.sv
// modulator model taking symbols from the serializer
`timescale 1ns/1ps
module tsx_sink
  import tsx_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // symbol stream
  input wire logic sym_valid_i,
  output logic sym_ready_o,
  input wire tsx_sym_t sym_i,
  // stall control and symbol log
  input wire logic stall_i,
  output logic [15:0] log_o
);
  assign sym_ready_o = !stall_i;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      log_o <= 16'h0000;
    end else if (sym_valid_i && sym_ready_o) begin
      log_o <= {log_o[13:0], sym_i};
    end
  end
endmodule

// ===== tb/tsx_serializer_asserts.sv
// assertions on the transmit serializer ports
`timescale 1ns/1ps
module tsx_serializer_asserts
  import tsx_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // watched ports
  input wire tsx_reg_req_t reg_req_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic tx_mode_i,
  input wire logic sym_valid_o,
  input wire logic sym_ready_i,
  input wire tsx_sym_t sym_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire logic rd_flags = reg_req_i.rd && reg_req_i.addr == OFS_EVENT_FLAGS;
  wire logic rd_mask = reg_req_i.rd && reg_req_i.addr == OFS_QUALIFIER_MASK;
  wire logic wr_mask = reg_req_i.wr && reg_req_i.addr == OFS_QUALIFIER_MASK;
  logic seen_sym;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      seen_sym <= 1'h0;
    end else if (sym_valid_o) begin
      seen_sym <= 1'h1;
    end
  end
  a_flags_idle_zero: assert property (
    rd_flags && !tx_mode_i |=> reg_rdata_o == 8'h00)
    else $error("flags not zero outside transmit mode");
  a_flags_rsvd_zero: assert property (
    rd_flags |=> reg_rvalid_o && reg_rdata_o[7:4] == RSVD_ZERO)
    else $error("reserved flag bits not zero");
  a_mask_readback: assert property (
    wr_mask ##2 rd_mask |=> reg_rdata_o == $past(reg_req_i.wdata, 3))
    else $error("mask readback wrong");
  a_preamble_low: assert property (
    sym_valid_o && !sym_o.is_data |-> !sym_o.value)
    else $error("preamble symbol carries a one");
  a_stall_holds: assert property (
    sym_valid_o && !sym_ready_i |=> sym_valid_o && $stable(sym_o))
    else $error("symbol changed while stalled");
  a_irq_needs_mode: assert property (
    !tx_mode_i |=> !irq_o)
    else $error("interrupt outside transmit mode");
  a_no_early_flags: assert property (
    rd_flags && !seen_sym && !sym_valid_o |=> reg_rdata_o[3:1] == 3'h0)
    else $error("underflow or done before any bit");
  a_rvalid_pulse: assert property (
    1'h1 |=> reg_rvalid_o == $past(reg_req_i.rd))
    else $error("read answer not one cycle after read");
endmodule
bind tsx_serializer tsx_serializer_asserts u_chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_req_i(reg_req_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .tx_mode_i(tx_mode_i), .sym_valid_o(sym_valid_o),
  .sym_ready_i(sym_ready_i), .sym_o(sym_o), .irq_o(irq_o));

// ===== tb/tb.sv
// testbench of the transmit serializer
`timescale 1ns/1ps
module tb;
  import tsx_pkg::*;
  logic clk_sys_i, rst_i, tx_mode_i, stall, reg_rvalid_o;
  logic sym_valid_o, sym_ready_i, irq_o;
  logic [7:0] reg_rdata_o;
  logic [15:0] log;
  tsx_reg_req_t reg_req_i;
  tsx_sym_t sym_o;
  int err_count, total_checks;
  tsx_serializer #(.DEPTH(2)) uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .tx_mode_i(tx_mode_i),
    .sym_valid_o(sym_valid_o), .sym_ready_i(sym_ready_i), .sym_o(sym_o),
    .irq_o(irq_o));
  tsx_sink u_sink (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .sym_valid_i(sym_valid_o), .sym_ready_o(sym_ready_i), .sym_i(sym_o),
    .stall_i(stall), .log_o(log));
  initial begin
    clk_sys_i = 1'h0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input string name, input logic [15:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys_i) #1;
    reg_req_i = '{rd: 1'h0, wr: 1'h1, addr: a, wdata: d};
    @(posedge clk_sys_i) #1;
    reg_req_i = '0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i) #1;
    reg_req_i = '{rd: 1'h1, wr: 1'h0, addr: a, wdata: 8'h00};
    @(posedge clk_sys_i) #1;
    reg_req_i = '0;
    chk("rdata", {8'h00, exp}, {8'h00, reg_rdata_o});
    chk("rvalid", 16'h1, {15'h0, reg_rvalid_o});
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    stop_test();
  end
  initial begin
    reg_req_i = '0;
    tx_mode_i = 1'h0;
    stall = 1'h1;
    rst_i = 1'h1;
    repeat (16) @(posedge clk_sys_i);
    #1 rst_i = 1'h0;
    rd(OFS_EVENT_FLAGS, 8'h00);
    rd(OFS_BYTE_HOLDING, BYTE_RESET);
    $display("test reset values done");
    tx_mode_i = 1'h1;
    repeat (4) @(posedge clk_sys_i);
    rd(OFS_EVENT_FLAGS, 8'h00);
    wr(OFS_IRQ_ENABLE, 8'h02);
    wr(OFS_QUALIFIER_MASK, 8'h0D);
    rd(OFS_QUALIFIER_MASK, 8'h0D);
    wr(OFS_BYTE_HOLDING, 8'hA5);
    repeat (4) @(posedge clk_sys_i);
    rd(OFS_EVENT_FLAGS, 8'h01);
    wr(OFS_BYTE_HOLDING, 8'h3C);
    wr(OFS_BYTE_HOLDING, 8'h3C);
    wr(OFS_EVENT_FLAGS, 8'hFF);
    rd(OFS_EVENT_FLAGS, 8'h04);
    rd(OFS_EVENT_FLAGS, 8'h00);
    $display("test overflow done");
    stall = 1'h0;
    repeat (40) @(posedge clk_sys_i);
    chk("log", 16'hCE8F, log);
    chk("irq", 16'h1, {15'h0, irq_o});
    rd(OFS_EVENT_FLAGS, 8'h0B);
    rd(OFS_EVENT_FLAGS, 8'h09);
    chk("irq", 16'h0, {15'h0, irq_o});
    tx_mode_i = 1'h0;
    rd(OFS_EVENT_FLAGS, 8'h00);
    $display("test stream done");
    stop_test();
  end
endmodule
